// ==== src/obc_decoder.sv ====
// Purpose: decode configuration bytes into hardware option outputs
// Assumes: AXI4-Lite register access, one 250 MHz clock
// Notes:   bytes reachable only in programming mode
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module obc_decoder (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output obc_pkg::obc_cfg_t        cfg,
  output obc_pkg::obc_range_t      range_sel,
  output logic                     pll_enable,
  output logic                     unbonded_pad_pullup,
  output logic                     user_mem_erase,
  output logic                     flash_read_block,
  output logic                     flash_write_block
);
  typedef enum logic [1:0] {OBC_IDLE, OBC_WIPE, OBC_CLEAR} obc_state_t;

  obc_state_t  state;
  logic [4:0]  wipe_cnt;
  logic        prog_mode;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        st_wr;
  logic        st_idx;
  logic [7:0]  st_data;
  logic        rd_idx;
  logic [7:0]  rd_byte;
  logic [7:0]  byte0;
  logic [7:0]  byte1;
  logic        cfg_fault;
  logic        rd_pending;
  logic [7:0]  ar_addr;
  logic        rd_wait;

  // write channels held separately so either order is accepted
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == obc_pkg::OFS_CTRL) s_axi_bresp <= 2'h0;
      else if (aw_addr == obc_pkg::OFS_PROG_DATA &&
               prog_mode && state == OBC_IDLE)
        s_axi_bresp <= 2'h0;
      else s_axi_bresp <= 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // programming mode flag steers access to the byte store
  always_ff @(posedge aclk) begin
    if (!aresetn) prog_mode <= 1'b0;
    else if (wr_fire && aw_addr == obc_pkg::OFS_CTRL && w_strb[0])
      prog_mode <= w_data[obc_pkg::CTRL_PROG_MODE];
  end

  // store write: data byte in lane 0, byte index in bit 8, the lowest bit of lane 1
  always_comb begin
    st_wr   = 1'b0;
    st_idx  = 1'b0;
    st_data = 8'h00;
    if (state == OBC_CLEAR) begin
      st_wr   = 1'b1;
      st_idx  = wipe_cnt[0];
      st_data = obc_pkg::ERASED_BYTE;
    end else if (wr_fire && aw_addr == obc_pkg::OFS_PROG_DATA &&
                 prog_mode && state == OBC_IDLE && w_strb[0]) begin
      st_wr   = 1'b1;
      st_idx  = w_data[8];
      st_data = w_data[7:0];
    end
  end

  // erasing while protected wipes user memory before the bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= OBC_IDLE;
      wipe_cnt <= 5'h00;
    end else begin
      case (state)
        OBC_IDLE: begin
          if (wr_fire && aw_addr == obc_pkg::OFS_CTRL && prog_mode &&
              w_strb[0] && w_data[obc_pkg::CTRL_ERASE]) begin
            wipe_cnt <= 5'h00;
            if (!byte0[obc_pkg::B0_ROP_N]) state <= OBC_WIPE;
            else state <= OBC_CLEAR;
          end
        end
        OBC_WIPE: begin
          if (wipe_cnt == 5'(obc_pkg::MEM_DEPTH - 1)) begin
            wipe_cnt <= 5'h00;
            state    <= OBC_CLEAR;
          end else begin
            wipe_cnt <= wipe_cnt + 5'h01;
          end
        end
        OBC_CLEAR: begin
          if (wipe_cnt == 5'h01) begin
            wipe_cnt <= 5'h00;
            state    <= OBC_IDLE;
          end else begin
            wipe_cnt <= wipe_cnt + 5'h01;
          end
        end
        default: state <= OBC_IDLE;
      endcase
    end
  end

  assign user_mem_erase = (state == OBC_WIPE);

  obc_store #(
    .DEPTH (2)
  ) u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (st_wr),
    .wr_idx  (st_idx),
    .wr_data (st_data),
    .rd_idx  (rd_idx),
    .rd_data (rd_byte),
    .byte0   (byte0),
    .byte1   (byte1)
  );

  // read side: one wait cycle for the registered store output
  assign s_axi_arready = !rd_pending && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pending <= 1'b0;
      ar_addr    <= 8'h00;
      rd_idx     <= 1'b0;
      rd_wait    <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_pending <= 1'b1;
      ar_addr    <= s_axi_araddr;
      rd_idx     <= 1'b0;
      rd_wait    <= 1'b1;
    end else if (rd_wait) begin
      rd_wait <= 1'b0;
    end else if (rd_pending) begin
      rd_pending <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (rd_pending && !rd_wait) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      if (ar_addr == obc_pkg::OFS_CTRL) begin
        s_axi_rdata <= {31'h0, prog_mode};
      end else if (ar_addr == obc_pkg::OFS_STATUS) begin
        s_axi_rdata <= {28'h0, cfg_fault, user_mem_erase,
                        state != OBC_IDLE, prog_mode};
      end else if (ar_addr == obc_pkg::OFS_DECODED) begin
        s_axi_rdata <= {16'h0, cfg.reset_cycles[12:8],
                        cfg.clock_source_type, cfg.oscillator_freq_range,
                        cfg.voltage_detect_threshold, pll_enable,
                        cfg.watchdog_type_sel, cfg.halt_watchdog_reset_sel,
                        cfg.readout_protect_n};
      end else if (ar_addr == obc_pkg::OFS_PROG_DATA && prog_mode) begin
        s_axi_rdata <= {16'h0, byte1, byte0};
      end else if (ar_addr == obc_pkg::OFS_RESET_CNT) begin
        s_axi_rdata <= {19'h0, cfg.reset_cycles};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // decoded settings: captured while reset is low, held afterwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.halt_watchdog_reset_sel   <= byte0[obc_pkg::B0_HALT_RST];
      cfg.watchdog_type_sel         <= byte0[obc_pkg::B0_WDG_TYPE];
      cfg.voltage_detect_threshold  <=
        byte0[obc_pkg::B0_VD_HI:obc_pkg::B0_VD_LO];
      cfg.low_supply_detector       <=
        byte0[obc_pkg::B0_VD_HI:obc_pkg::B0_VD_LO] != obc_pkg::VD_OFF;
      cfg.auxiliary_supply_detector <=
        byte0[obc_pkg::B0_VD_HI:obc_pkg::B0_VD_LO] != obc_pkg::VD_OFF;
      cfg.package_sel_lo            <= byte0[obc_pkg::B0_PKG_LO];
      cfg.package_sel_hi            <= byte1[obc_pkg::B1_PKG_HI];
      cfg.readout_protect_n         <= byte0[obc_pkg::B0_ROP_N];
      cfg.reset_phase_length_sel    <= byte1[obc_pkg::B1_RST_LEN];
      cfg.reset_cycles              <= byte1[obc_pkg::B1_RST_LEN] ?
        obc_pkg::RST_SHORT : obc_pkg::RST_LONG;
      cfg.clock_source_type         <=
        byte1[obc_pkg::B1_CLK_HI:obc_pkg::B1_CLK_LO];
      cfg.oscillator_freq_range     <=
        byte1[obc_pkg::B1_RNG_HI:obc_pkg::B1_RNG_LO];
      cfg.freq_doubler_disable      <= byte1[obc_pkg::B1_PLL_OFF];
    end
  end

  always_comb begin
    range_sel.range_low_power    = cfg.oscillator_freq_range == 3'h0;
    range_sel.range_medium_power = cfg.oscillator_freq_range == 3'h1;
    range_sel.range_medium_speed = cfg.oscillator_freq_range == 3'h2;
    range_sel.range_high_speed   = cfg.oscillator_freq_range == 3'h3;
  end

  // the doubler is gated off outside its guaranteed input range
  assign pll_enable = !cfg.freq_doubler_disable &&
    cfg.oscillator_freq_range == obc_pkg::RANGE_MP &&
    cfg.clock_source_type != obc_pkg::CLK_RC &&
    cfg.clock_source_type != obc_pkg::CLK_EXTERNAL;

  // protection follows the captured option, even in programming mode
  assign flash_read_block  = !cfg.readout_protect_n;
  assign flash_write_block = !cfg.readout_protect_n;

  // unbonded pads always come up as pulled-up inputs
  assign unbonded_pad_pullup = 1'b1;

  // flags settings the far side should not have chosen
  assign cfg_fault = (!cfg.readout_protect_n && cfg.low_supply_detector) ||
    (cfg.clock_source_type == obc_pkg::CLK_RESONATOR &&
     cfg.reset_phase_length_sel) ||
    cfg.clock_source_type == obc_pkg::CLK_RESERVED;
endmodule : obc_decoder

// ==== shared/obc_pkg.sv ====
// Purpose: constants and carriers for the configuration byte decoder
// Assumes: two 8-bit configuration bytes, erased value all ones
// Notes:   offsets are byte addresses on the register bus
package obc_pkg;
  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 8;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_DECODED    = 8'h08;
  localparam logic [7:0]  OFS_PROG_DATA  = 8'h0C;
  localparam logic [7:0]  OFS_RESET_CNT  = 8'h10;
  // control bits
  localparam int          CTRL_PROG_MODE = 0;
  localparam int          CTRL_WRITE     = 1;
  localparam int          CTRL_ERASE     = 2;
  // erased content and shipped content
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [7:0]  SHIP_BYTE0     = 8'hE7;
  localparam logic [7:0]  SHIP_BYTE1     = 8'hEF;
  // byte 0 field positions
  localparam int          B0_HALT_RST    = 7;
  localparam int          B0_WDG_TYPE    = 6;
  localparam int          B0_VD_HI       = 4;
  localparam int          B0_VD_LO       = 3;
  localparam int          B0_PKG_LO      = 1;
  localparam int          B0_ROP_N       = 0;
  // byte 1 field positions
  localparam int          B1_PKG_HI      = 7;
  localparam int          B1_RST_LEN     = 6;
  localparam int          B1_CLK_HI      = 5;
  localparam int          B1_CLK_LO      = 4;
  localparam int          B1_RNG_HI      = 3;
  localparam int          B1_RNG_LO      = 1;
  localparam int          B1_PLL_OFF     = 0;
  // voltage detect encodings
  localparam logic [1:0]  VD_OFF         = 2'h3;
  // clock source and oscillator range encodings
  localparam logic [1:0]  CLK_RESONATOR  = 2'h0;
  localparam logic [1:0]  CLK_RESERVED   = 2'h1;
  localparam logic [1:0]  CLK_RC         = 2'h2;
  localparam logic [1:0]  CLK_EXTERNAL   = 2'h3;
  localparam logic [2:0]  RANGE_MP       = 3'h1;
  // reset phase lengths in cpu cycles
  localparam logic [12:0] RST_LONG       = 13'h1000;
  localparam logic [12:0] RST_SHORT      = 13'h0100;
  // memory erase walk
  localparam int          MEM_DEPTH      = 16;

  typedef struct packed {
    logic        halt_watchdog_reset_sel;
    logic        watchdog_type_sel;
    logic [1:0]  voltage_detect_threshold;
    logic        low_supply_detector;
    logic        auxiliary_supply_detector;
    logic        package_sel_lo;
    logic        package_sel_hi;
    logic        readout_protect_n;
    logic        reset_phase_length_sel;
    logic [1:0]  clock_source_type;
    logic [2:0]  oscillator_freq_range;
    logic        freq_doubler_disable;
    logic [12:0] reset_cycles;
  } obc_cfg_t;

  typedef struct packed {
    logic        range_low_power;
    logic        range_medium_power;
    logic        range_medium_speed;
    logic        range_high_speed;
  } obc_range_t;
endpackage : obc_pkg

// ==== src/obc_store.sv ====
// Purpose: small word store for the two configuration bytes
// Assumes: one write port, registered read data
// Notes:   resets to the shipped content
`timescale 1ns/10ps
module obc_store #(
  parameter int DEPTH = 2
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       wr_en,
  input  wire logic       wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_idx,
  output logic      [7:0] rd_data,
  output logic      [7:0] byte0,
  output logic      [7:0] byte1
);
  logic [7:0] mem [DEPTH];

  // refuse depths the two fixed byte taps cannot serve
  if (DEPTH != 2) begin : g_depth_check
    $error("obc_store holds exactly two bytes");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem[0] <= obc_pkg::SHIP_BYTE0;
      mem[1] <= obc_pkg::SHIP_BYTE1;
    end else if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) rd_data <= 8'h00;
    else rd_data <= mem[rd_idx];
  end

  assign byte0 = mem[0];
  assign byte1 = mem[1];
endmodule : obc_store

// ==== tb/obc_decoder_chk.sv ====
// Purpose: property checks on the decoded option outputs
// Assumes: bound to obc_decoder, one clock domain
// Notes:   bus timing is judged by the bench
`timescale 1ns/10ps
module obc_decoder_chk (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire obc_pkg::obc_cfg_t   cfg,
  input wire obc_pkg::obc_range_t range_sel,
  input wire logic                pll_enable,
  input wire logic                unbonded_pad_pullup,
  input wire logic                user_mem_erase,
  input wire logic                flash_read_block,
  input wire logic                flash_write_block,
  input wire logic                s_axi_bvalid,
  input wire logic [1:0]          s_axi_bresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wipe8;
    user_mem_erase [*8];
  endsequence
  a_cfg_hold: assert property ($past(aresetn) |-> $stable(cfg))
    else $error("cfg moved outside reset");
  a_prot_block: assert property (
    flash_read_block == !cfg.readout_protect_n &&
    flash_write_block == !cfg.readout_protect_n)
    else $error("protection outputs wrong");
  a_detect_on: assert property (cfg.low_supply_detector ==
    (cfg.voltage_detect_threshold != 2'h3)
    && cfg.auxiliary_supply_detector == cfg.low_supply_detector)
    else $error("detector enables wrong");
  a_reset_len: assert property (cfg.reset_cycles ==
    (cfg.reset_phase_length_sel ? 13'h0100 : 13'h1000))
    else $error("reset length wrong");
  a_pll_gate: assert property (
    pll_enable == (!cfg.freq_doubler_disable &&
    cfg.oscillator_freq_range == 3'h1 && !cfg.clock_source_type[1]))
    else $error("doubler enable wrong");
  a_range_dec: assert property (range_sel == {
    cfg.oscillator_freq_range == 3'h0, cfg.oscillator_freq_range == 3'h1,
    cfg.oscillator_freq_range == 3'h2, cfg.oscillator_freq_range == 3'h3})
    else $error("range decode wrong");
  a_pad_pull: assert property (unbonded_pad_pullup)
    else $error("pad pull-up low");
  a_wipe_len: assert property ($rose(user_mem_erase) |->
    s_wipe8 ##1 s_wipe8 ##1 !user_mem_erase)
    else $error("wipe length wrong");
  // the wipe starts with the accepted erase command, never on its own
  a_wipe_why: assert property ($rose(user_mem_erase) |->
    $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
    else $error("wipe without erase command");
endmodule : obc_decoder_chk

bind obc_decoder obc_decoder_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .cfg(cfg), .range_sel(range_sel),
  .pll_enable(pll_enable), .unbonded_pad_pullup(unbonded_pad_pullup),
  .user_mem_erase(user_mem_erase), .flash_read_block(flash_read_block),
  .flash_write_block(flash_write_block), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp)
);

// ==== tb/obc_prog_tool.sv ====
// Purpose: programming tool model, bus master towards the decoder
// Assumes: one write and one read at most under way
// Notes:   released address and data lines show the inverse of their last value, wstrb stays at F
`timescale 1ns/10ps
module obc_prog_tool (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 16'h0000;
    wdata = 32'h0;
    wstrb = 4'hF;
  end
  // ready is looked at mid-cycle so the decision is taken at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta;
    logic tw;
    logic tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (ta) awaddr <= ~awaddr;
      if (tw) wvalid <= 1'b0;
      if (tw) wdata <= ~wdata;
      if (tb) bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta;
    logic tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (ta) araddr <= ~araddr;
      if (tr) rready <= 1'b0;
    end
  endtask : rd
  task automatic prog(input logic idx, input logic [7:0] v,
                      output logic [1:0] r);
    logic [7:0] b;
    b = v;
    if (!idx) b = b | 8'h24;
    if (!idx && !b[0]) b[4:3] = 2'h3;
    if (idx && b[5:4] == 2'h0) b[6] = 1'b0;
    if (idx && (b[3:1] != 3'h1 || b[5])) b[0] = 1'b1;
    wr(obc_pkg::OFS_PROG_DATA, {23'h0, idx, b}, r);
  endtask : prog
endmodule : obc_prog_tool

// ==== tb/tb_obc_decoder.sv ====
// Purpose: self-checking bench for the option byte decoder
// Assumes: 250 MHz clock, reset held 6 cycles
// Notes:   the store reloads shipped bytes on every reset
`timescale 1ns/10ps
module tb_obc_decoder;
  logic                aclk;
  logic                aresetn;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready;
  obc_pkg::obc_cfg_t   cfg;
  obc_pkg::obc_range_t range_sel;
  logic                pll_enable, pad_pullup, mem_erase, rd_blk, wr_blk;
  int                  failures;
  int                  checked;
  int                  wipe_cycles;

  obc_decoder i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg(cfg),
    .range_sel(range_sel), .pll_enable(pll_enable),
    .unbonded_pad_pullup(pad_pullup), .user_mem_erase(mem_erase),
    .flash_read_block(rd_blk), .flash_write_block(wr_blk)
  );
  obc_prog_tool i_tool (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  // counts cycles of user memory wipe, sampled where it is settled
  always @(negedge aclk) begin
    if (mem_erase === 1'b1) wipe_cycles++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  // shipped bytes: E7 and EF, expectation decoded bit by bit
  task automatic t_shipped;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [2:0]  g;
    logic [28:0] e;
    b0 = 8'hE7;
    b1 = 8'hEF;
    g = b1[3:1];
    e = {b0[7:6], b0[4:3], {2{b0[4:3] != 2'h3}}, b0[1], b1[7], b0[0],
         b1[6:0], b1[6] ? 13'h0100 : 13'h1000};
    @(negedge aclk);
    check(cfg, e);
    check(cfg.clock_source_type, 2'h2);
    check(pll_enable, !b1[0] && g == 3'h1 && !b1[5]);
    check(range_sel, {g == 3'h0, g == 3'h1, g == 3'h2, g == 3'h3});
    check({rd_blk, wr_blk}, {2{~b0[0]}});
    check(pad_pullup, 1'b1);
  endtask : t_shipped
  task automatic t_refuse;
    logic [31:0] d;
    logic [1:0]  r;
    i_tool.wr(obc_pkg::OFS_PROG_DATA, 32'h000000FF, r);
    check(r, 2'h2);
    i_tool.rd(obc_pkg::OFS_PROG_DATA, d, r);
    check(r, 2'h2);
    i_tool.rd(8'h14, d, r);
    check({d[29:0], r}, 32'h2);
  endtask : t_refuse
  task automatic t_program;
    logic [31:0] d;
    logic [1:0]  r;
    i_tool.wr(obc_pkg::OFS_CTRL, 32'h1, r);
    i_tool.prog(1'b0, 8'h3D, r);
    check(r, 2'h0);
    i_tool.prog(1'b1, 8'h82, r);
    i_tool.rd(obc_pkg::OFS_PROG_DATA, d, r);
    check(d[15:0], 16'h823D);
    t_shipped;
  endtask : t_program
  // erase with protection off, then on: only the latter wipes user memory
  task automatic t_erase(input logic prot);
    logic [31:0] d;
    logic [1:0]  r;
    wipe_cycles = 0;
    i_tool.prog(1'b0, {7'h1E, ~prot}, r);
    i_tool.wr(obc_pkg::OFS_CTRL, 32'h5, r);
    if (prot) begin
      i_tool.prog(1'b1, 8'h00, r);
      check(r, 2'h2);
    end
    for (int n = 0; n < 50; n++) begin
      i_tool.rd(obc_pkg::OFS_STATUS, d, r);
      if (d[1] === 1'b0) break;
    end
    i_tool.rd(obc_pkg::OFS_PROG_DATA, d, r);
    check(d[15:0], 16'hFFFF);
    check(mem_erase, 1'b0);
    check(wipe_cycles, prot ? obc_pkg::MEM_DEPTH : 0);
  endtask : t_erase
  task automatic t_rereset;
    logic [31:0] d;
    logic [1:0]  r;
    do_reset;
    t_shipped;
    i_tool.rd(obc_pkg::OFS_PROG_DATA, d, r);
    check(r, 2'h2);
  endtask : t_rereset

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    conclude;
  end
  initial begin
    aresetn = 1'b0;
    failures = 0;
    checked = 0;
    do_reset;
    t_shipped;
    t_refuse;
    t_program;
    t_erase(1'b0);
    t_erase(1'b1);
    t_rereset;
    conclude;
  end
endmodule : tb_obc_decoder
